// *** dio_mapper.sv ***
// discrete input/output terminal mapper of the servo drive
//
// Contract
// (RL1) each of four input terminals maps to a function by its own selector, mode dependent
// (RL2) each of two output terminals shows a status function chosen by its selector
// (RL3) reset selectors: in1=2, in2=11, in3=in4=0, out1=2, out2=9
// (RL4) a selected input change takes effect after 8 to 16 ms
// (RL5) inversion bit 0 inverts output 1, bit 1 inverts output 2
// (RL6) seven input functions are available to the selectors
// (RL7) torque select low picks limit 1, high picks limit 2, by level
// (RL8) speed select low picks limit 1, high picks limit 2, by level
// (RL9) quick stop input low stops, high means ready to run, by level
// (RL10) homing rising edge sets reference point, or is cam event in approach mode
// (RL11) positive travel limit held high permits running; its falling edge starts quick stop
// (RL12) negative travel limit held high permits running; its falling edge starts quick stop
// (RL13) ten output status functions are available to the selectors
// (RL14) servo ready is high when ready, low on fault or missing enable
// (RL15) zero speed high at or below threshold, low above threshold plus hysteresis
// (RL16) torque limit reached when torque is within hysteresis of either limit
// (RL17) brake status high while brake engaged, low while released, status only
// (RL18) overload high at configurable percent level, default 100, maximum 300
// (RL19) ready for servo on low on fault, no main power, or control bits 1,2 unset
// (RL20) in position high when following error lies inside the window
// (RL21) safe torque off status high while safety enable is missing
// (RL22) alarm reset clears alarms on rising edge only
// (RL23) fault status follows fault state; homed status high once homing is done
`timescale 1ns/1ps
module dio_mapper
  import dio_map_pkg::*;
#(
  parameter int TICK_CYCLES = DI_TICK_CYCLES
) (
  // clock, reset, enable
  input wire logic clock,
  input wire logic srst,
  input wire logic ce,
  // register port
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [31:0] rdata,
  // terminals
  input wire logic input_terminal_1,
  input wire logic input_terminal_2,
  input wire logic input_terminal_3,
  input wire logic input_terminal_4,
  output logic output_terminal_1,
  output logic output_terminal_2,
  // drive state
  input wire logic [1:0] control_mode,
  input wire logic ref_approach_mode,
  input wire logic fault_active,
  input wire logic enable_present,
  input wire logic main_power_ok,
  input wire logic [15:0] drive_control_word,
  input wire logic [15:0] motor_speed,
  input wire logic signed [15:0] torque_actual,
  input wire logic [15:0] torque_pos_limit,
  input wire logic [15:0] torque_neg_limit,
  input wire logic [8:0] load_pct,
  input wire logic brake_engaged,
  input wire logic signed [15:0] following_error,
  input wire logic homing_done,
  input wire logic safety_enable,
  // commands to the drive
  output logic alarm_clear_pulse,
  output logic reference_set_pulse,
  output logic reference_cam_pulse,
  output logic quick_stop_ramp,
  output logic quick_stop_request,
  output logic torque_limit_select,
  output logic speed_limit_select
);

  localparam int CNT_W = $clog2(TICK_CYCLES + 1);
  localparam logic [CNT_W-1:0] TICK_LAST = CNT_W'(TICK_CYCLES - 1);

  // function bit positions inside the level vector
  localparam int L_RST = 0;
  localparam int L_POS = 1;
  localparam int L_NEG = 2;
  localparam int L_QS = 3;
  localparam int L_TQ = 4;
  localparam int L_SP = 5;
  localparam int L_HOME = 6;

  logic [15:0] in_sel_r;
  logic [7:0] out_sel_r;
  logic [1:0] out_inv_r;
  logic [15:0] zsp_thr_r;
  logic [8:0] oll_thr_r;
  logic [15:0] win_r;
  logic [CNT_W-1:0] tick_cnt_r;
  logic tick_r;
  logic [3:0] pins;
  logic [3:0] sync1_r;
  logic [3:0] sync2_r;
  logic [3:0] samp_r;
  logic [3:0] filt_r;
  logic [6:0] lvl_nxt;
  logic [6:0] lvl_r;
  logic zsp_r;
  logic [10:0] st;
  logic [31:0] rdata_nxt;
  logic [8:0] oll_wr;

  assign pins = {input_terminal_4, input_terminal_3, input_terminal_2, input_terminal_1};

  // magnitude of a signed word, one bit wider so that the most negative value fits
  function automatic logic [16:0] mag17(input logic signed [15:0] v);
    logic [16:0] e;
    e = {v[15], v};
    return v[15] ? 17'(-e) : e;
  endfunction

  // functions offered in the present control mode; homing only in position mode
  function automatic logic fn_allowed(input logic [1:0] mode, input logic [3:0] code);
    logic ok;
    ok = 1'b0;
    case (code)
      IFN_ALARM_RESET, IFN_POS_LIMIT, IFN_NEG_LIMIT,
      IFN_QUICK_STOP, IFN_TORQUE_SEL, IFN_SPEED_SEL: ok = 1'b1;
      IFN_HOMING: ok = (mode == MODE_POSITION);
      default: ok = 1'b0;
    endcase
    return ok;
  endfunction

  // level of one function; the lowest terminal wins when several carry it
  function automatic logic fn_level(input logic [15:0] sel, input logic [3:0] lv,
                                    input logic [1:0] mode, input logic [3:0] code,
                                    input logic dflt);
    logic v;
    v = dflt;
    for (int i = 3; i >= 0; i--) begin
      if (sel[4*i +: 4] == code && fn_allowed(mode, code)) begin
        v = lv[i];
      end
    end
    return v;
  endfunction

  // register writes
  assign oll_wr = (wdata[8:0] > OLL_MAX_PCT) ? OLL_MAX_PCT : wdata[8:0]; // RL18

  always_ff @(posedge clock) begin
    if (ce && srst) begin
      in_sel_r <= RST_IN_SEL; // RL3
      out_sel_r <= RST_OUT_SEL; // RL3
      out_inv_r <= RST_OUT_INV;
      zsp_thr_r <= RST_ZSP_THR;
      oll_thr_r <= RST_OLL_PCT; // RL18
      win_r <= RST_WIN_SIZE;
    end else if (ce && wr_en) begin
      case (addr)
        OFS_IN_SEL: in_sel_r <= wdata[15:0]; // RL1
        OFS_OUT_SEL: out_sel_r <= wdata[7:0]; // RL2
        OFS_OUT_INV: out_inv_r <= wdata[1:0];
        OFS_ZSP_THR: zsp_thr_r <= wdata[15:0];
        OFS_OLL_THR: oll_thr_r <= oll_wr;
        OFS_WIN_SIZE: win_r <= wdata[15:0];
        default: ;
      endcase
    end
  end

  // read data stand for exactly one cycle after the strobe
  always_comb begin
    rdata_nxt = 32'h0000_0000;
    case (addr)
      OFS_IN_SEL: rdata_nxt = {16'h0000, in_sel_r};
      OFS_OUT_SEL: rdata_nxt = {24'h00_0000, out_sel_r};
      OFS_OUT_INV: rdata_nxt = {30'h0000_0000, out_inv_r};
      OFS_ZSP_THR: rdata_nxt = {16'h0000, zsp_thr_r};
      OFS_OLL_THR: rdata_nxt = {23'h00_0000, oll_thr_r};
      OFS_WIN_SIZE: rdata_nxt = {16'h0000, win_r};
      OFS_STATUS: rdata_nxt = {6'h00, st[10:1], 1'b0, lvl_r, 2'h0,
                               output_terminal_2, output_terminal_1, filt_r};
      default: rdata_nxt = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clock) begin
    if (ce && srst) begin
      rdata <= 32'h0000_0000;
    end else if (ce) begin
      rdata <= rd_en ? rdata_nxt : 32'h0000_0000;
    end
  end

  // sample tick: one period of the input filter
  always_ff @(posedge clock) begin
    if (ce && srst) begin
      tick_cnt_r <= '0;
      tick_r <= 1'b0;
    end else if (ce) begin
      tick_r <= (tick_cnt_r == TICK_LAST);
      tick_cnt_r <= (tick_cnt_r == TICK_LAST) ? '0 : tick_cnt_r + 1'b1;
    end
  end

  // per terminal: two-stage synchroniser, then accept a level seen on two
  // successive ticks, which gives one to two tick periods of latency
  // and also rejects chatter shorter than one period
  for (genvar g = 0; g < 4; g++) begin : g_term
    always_ff @(posedge clock) begin
      if (ce && srst) begin
        sync1_r[g] <= 1'b0;
        sync2_r[g] <= 1'b0;
        samp_r[g] <= 1'b0;
        filt_r[g] <= 1'b0;
      end else if (ce) begin
        sync1_r[g] <= pins[g];
        sync2_r[g] <= sync1_r[g];
        if (tick_r) begin
          samp_r[g] <= sync2_r[g];
          if (sync2_r[g] == samp_r[g]) begin
            filt_r[g] <= sync2_r[g]; // RL4
          end
        end
      end
    end
  end

  // function levels; unmapped limits and quick stop read as permissive high
  always_comb begin
    lvl_nxt[L_RST] = fn_level(in_sel_r, filt_r, control_mode, IFN_ALARM_RESET, 1'b0); // RL6
    lvl_nxt[L_POS] = fn_level(in_sel_r, filt_r, control_mode, IFN_POS_LIMIT, 1'b1);
    lvl_nxt[L_NEG] = fn_level(in_sel_r, filt_r, control_mode, IFN_NEG_LIMIT, 1'b1);
    lvl_nxt[L_QS] = fn_level(in_sel_r, filt_r, control_mode, IFN_QUICK_STOP, 1'b1);
    lvl_nxt[L_TQ] = fn_level(in_sel_r, filt_r, control_mode, IFN_TORQUE_SEL, 1'b0);
    lvl_nxt[L_SP] = fn_level(in_sel_r, filt_r, control_mode, IFN_SPEED_SEL, 1'b0);
    lvl_nxt[L_HOME] = fn_level(in_sel_r, filt_r, control_mode, IFN_HOMING, 1'b0);
  end

  // reset value zero so that release of reset gives no falling edge on a limit
  always_ff @(posedge clock) begin
    if (ce && srst) begin
      lvl_r <= 7'h00;
    end else if (ce) begin
      lvl_r <= lvl_nxt;
    end
  end

  // level commands
  always_ff @(posedge clock) begin
    if (ce && srst) begin
      torque_limit_select <= 1'b0;
      speed_limit_select <= 1'b0;
      quick_stop_request <= 1'b0;
    end else if (ce) begin
      torque_limit_select <= lvl_nxt[L_TQ]; // RL7
      speed_limit_select <= lvl_nxt[L_SP]; // RL8
      quick_stop_request <= ~lvl_nxt[L_QS]; // RL9
    end
  end

  // edge commands, one cycle each
  always_ff @(posedge clock) begin
    if (ce && srst) begin
      alarm_clear_pulse <= 1'b0;
      reference_set_pulse <= 1'b0;
      reference_cam_pulse <= 1'b0;
      quick_stop_ramp <= 1'b0;
    end else if (ce) begin
      alarm_clear_pulse <= lvl_nxt[L_RST] & ~lvl_r[L_RST]; // RL22
      reference_set_pulse <= lvl_nxt[L_HOME] & ~lvl_r[L_HOME] & ~ref_approach_mode; // RL10
      reference_cam_pulse <= lvl_nxt[L_HOME] & ~lvl_r[L_HOME] & ref_approach_mode; // RL10
      quick_stop_ramp <= (~lvl_nxt[L_POS] & lvl_r[L_POS]) // RL11
                       | (~lvl_nxt[L_NEG] & lvl_r[L_NEG]); // RL12
    end
  end

  // zero speed with hysteresis on the way out
  always_ff @(posedge clock) begin
    if (ce && srst) begin
      zsp_r <= 1'b0;
    end else if (ce) begin
      if (motor_speed <= zsp_thr_r) begin
        zsp_r <= 1'b1; // RL15
      end else if ({1'b0, motor_speed} > {1'b0, zsp_thr_r} + {1'b0, ZSP_HYST_RPM}) begin
        zsp_r <= 1'b0; // RL15
      end
    end
  end

  // status vector indexed by output function code
  always_comb begin
    st = '0;
    st[OFN_READY] = ~fault_active & enable_present; // RL14
    st[OFN_FAULT] = fault_active; // RL23
    st[OFN_IN_POS] = mag17(following_error) <= {1'b0, win_r}; // RL20
    st[OFN_ZERO_SPEED] = zsp_r;
    st[OFN_TORQUE_LIM] = // RL16
      (~torque_actual[15] & (mag17(torque_actual) + {1'b0, TLR_HYST} >= {1'b0, torque_pos_limit}))
      | (torque_actual[15] & (mag17(torque_actual) + {1'b0, TLR_HYST} >= {1'b0, torque_neg_limit}));
    st[OFN_BRAKE] = brake_engaged; // RL17
    st[OFN_READY_ON] = ~fault_active & main_power_ok // RL19
                     & drive_control_word[1] & drive_control_word[2];
    st[OFN_HOMED] = homing_done; // RL23
    st[OFN_OVERLOAD] = load_pct >= oll_thr_r; // RL18
    st[OFN_SAFE_OFF] = ~safety_enable; // RL21
  end

  // codes 0 and above ten drive the terminal low before inversion
  always_ff @(posedge clock) begin
    if (ce && srst) begin
      output_terminal_1 <= 1'b0;
      output_terminal_2 <= 1'b0;
    end else if (ce) begin
      output_terminal_1 <= (out_sel_r[3:0] <= OFN_SAFE_OFF ? st[out_sel_r[3:0]] : 1'b0) // RL13
                         ^ out_inv_r[0]; // RL5
      output_terminal_2 <= (out_sel_r[7:4] <= OFN_SAFE_OFF ? st[out_sel_r[7:4]] : 1'b0) // RL2
                         ^ out_inv_r[1]; // RL5
    end
  end

  // checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (srst);

  a_reset_defaults: assert property ( // RL3
    disable iff (1'b0) ce && srst |=> in_sel_r == RST_IN_SEL && out_sel_r == RST_OUT_SEL)
    else $error("selectors not at reset defaults");

  a_filter_on_tick: assert property ( // RL4
    !$stable(filt_r) |-> $past(tick_r))
    else $error("filtered input changed away from a tick");

  a_filter_agree: assert property ( // RL4
    $changed(filt_r) |-> filt_r == $past(samp_r))
    else $error("filtered input took an unconfirmed sample");

  a_invert_out1: assert property ( // RL5
    ce && out_sel_r[3:0] == OFN_FAULT |=> output_terminal_1 == ($past(fault_active) ^ $past(out_inv_r[0])))
    else $error("output 1 level or inversion wrong");

  a_torque_select: assert property ( // RL7
    ce |=> torque_limit_select == $past(lvl_nxt[L_TQ]))
    else $error("torque limit select not following its input");

  a_quick_stop_lvl: assert property ( // RL9
    ce |=> quick_stop_request == !$past(lvl_nxt[L_QS]))
    else $error("quick stop level wrong");

  a_limit_fall: assert property ( // RL11
    ce && lvl_r[L_POS] && !lvl_nxt[L_POS] |=> quick_stop_ramp ##1 (!quick_stop_ramp || !$past(ce)))
    else $error("travel limit fall did not give one quick stop pulse");

  a_alarm_steady: assert property ( // RL22
    ce && lvl_r[L_RST] == lvl_nxt[L_RST] |=> !alarm_clear_pulse)
    else $error("alarm clear without a rising edge");

  a_zero_speed_hold: assert property ( // RL15
    ce && zsp_r && motor_speed > zsp_thr_r
    && {1'b0, motor_speed} <= {1'b0, zsp_thr_r} + {1'b0, ZSP_HYST_RPM} |=> zsp_r)
    else $error("zero speed dropped inside hysteresis");

  a_overload_clamp: assert property ( // RL18
    oll_thr_r <= OLL_MAX_PCT)
    else $error("overload level above maximum");

  a_read_one_cycle: assert property (
    ce && !rd_en |=> rdata == 32'h0000_0000)
    else $error("read data outside the answer cycle");

  c_alarm_clear: cover property (alarm_clear_pulse);
  c_ref_cam: cover property (reference_cam_pulse);
  c_limit_stop: cover property (quick_stop_ramp);
  c_out2_high: cover property (output_terminal_2 ##1 !output_terminal_2);

endmodule

// *** dio_map_pkg.sv ***
// constants shared by the discrete input/output mapper
package dio_map_pkg;
  // register byte offsets
  localparam logic [7:0] OFS_IN_SEL = 8'h00;
  localparam logic [7:0] OFS_OUT_SEL = 8'h04;
  localparam logic [7:0] OFS_OUT_INV = 8'h08;
  localparam logic [7:0] OFS_ZSP_THR = 8'h0C;
  localparam logic [7:0] OFS_OLL_THR = 8'h10;
  localparam logic [7:0] OFS_WIN_SIZE = 8'h14;
  localparam logic [7:0] OFS_STATUS = 8'h18;
  // values after reset
  localparam logic [15:0] RST_IN_SEL = 16'h00B2;
  localparam logic [7:0] RST_OUT_SEL = 8'h92;
  localparam logic [1:0] RST_OUT_INV = 2'h0;
  localparam logic [15:0] RST_ZSP_THR = 16'h0014;
  localparam logic [8:0] RST_OLL_PCT = 9'h064;
  localparam logic [15:0] RST_WIN_SIZE = 16'h0028;
  // fixed figures
  localparam logic [15:0] ZSP_HYST_RPM = 16'h000A;
  localparam logic [8:0] OLL_MAX_PCT = 9'h12C;
  localparam logic [15:0] TLR_HYST = 16'h0010;
  // input filter timing: one sample period is the least latency
  localparam int DI_DELAY_MS = 8;
  localparam int CLK_KHZ = 125000;
  localparam int DI_TICK_CYCLES = DI_DELAY_MS * CLK_KHZ;
  // input function codes
  localparam logic [3:0] IFN_NONE = 4'h0;
  localparam logic [3:0] IFN_ALARM_RESET = 4'h2;
  localparam logic [3:0] IFN_POS_LIMIT = 4'h3;
  localparam logic [3:0] IFN_NEG_LIMIT = 4'h4;
  localparam logic [3:0] IFN_QUICK_STOP = 4'h5;
  localparam logic [3:0] IFN_TORQUE_SEL = 4'hB;
  localparam logic [3:0] IFN_SPEED_SEL = 4'hC;
  localparam logic [3:0] IFN_HOMING = 4'hD;
  // output status function codes
  localparam logic [3:0] OFN_READY = 4'h1;
  localparam logic [3:0] OFN_FAULT = 4'h2;
  localparam logic [3:0] OFN_IN_POS = 4'h3;
  localparam logic [3:0] OFN_ZERO_SPEED = 4'h4;
  localparam logic [3:0] OFN_TORQUE_LIM = 4'h5;
  localparam logic [3:0] OFN_BRAKE = 4'h6;
  localparam logic [3:0] OFN_READY_ON = 4'h7;
  localparam logic [3:0] OFN_HOMED = 4'h8;
  localparam logic [3:0] OFN_OVERLOAD = 4'h9;
  localparam logic [3:0] OFN_SAFE_OFF = 4'hA;
  // control modes
  localparam logic [1:0] MODE_POSITION = 2'h0;
  localparam logic [1:0] MODE_SPEED = 2'h1;
endpackage

// *** plc_model.sv ***
// behavioural model of the controller wired to the four input terminals
`timescale 1ns/1ps
module plc_model (
  // clock
  input wire logic clock,
  // levels the controller wants on its lines
  input wire logic [3:0] level_cmd,
  // wires towards the drive
  output logic [3:0] pins
);
  // wiring is not clock aligned, so lines move a few ns after the edge
  always @(posedge clock) begin
    pins <= #3 level_cmd;
  end
endmodule

// *** servo_drive_discrete_io_mapper_test.sv ***
// self-checking bench for the discrete terminal mapper
`timescale 1ns/1ps
module servo_drive_discrete_io_mapper_test;
  import dio_map_pkg::*;
  localparam int T = 8;
  logic clock = 0, srst = 1, ce = 1, wr_en = 0, rd_en = 0, ot1, ot2, zero_speed_status = 1;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000, rdata, lfsr = 32'hda0a_0d1e, r, v;
  logic [31:0] rst_v [8] = '{32'h0000_00b2, 32'h0000_0092, 32'h0, 32'h0000_0014,
    32'h0000_0064, 32'h0000_0028, 32'h0, 32'h0};
  logic [3:0] lv = 4'h0, pins;
  logic [1:0] control_mode = 2'h0, inv = 2'h0;
  logic ref_approach_mode = 0, fault_active = 0, enable_present = 0, main_power_ok = 0;
  logic brake_engaged = 0, homing_done = 0, safety_enable = 0;
  logic [15:0] drive_control_word = 16'h0, motor_speed = 16'h0;
  logic [15:0] torque_pos_limit = 16'h0, torque_neg_limit = 16'h0;
  logic signed [15:0] torque_actual = 16'sh0, following_error = 16'sh0;
  logic [8:0] load_pct = 9'h000;
  logic alarm_clear_pulse, reference_set_pulse, reference_cam_pulse, quick_stop_ramp;
  logic quick_stop_request, torque_limit_select, speed_limit_select;
  logic [6:0] cmd;
  int mismatches = 0, checked = 0;

  assign cmd = {alarm_clear_pulse, reference_set_pulse, reference_cam_pulse,
    quick_stop_ramp, quick_stop_request, torque_limit_select, speed_limit_select};

  always #4 clock = ~clock;

  plc_model plc_u (.clock, .level_cmd(lv), .pins);

  dio_mapper #(.TICK_CYCLES(T)) dut_u (.clock, .srst, .ce, .addr, .wdata, .wr_en, .rd_en,
    .rdata, .input_terminal_1(pins[0]), .input_terminal_2(pins[1]),
    .input_terminal_3(pins[2]), .input_terminal_4(pins[3]), .output_terminal_1(ot1),
    .output_terminal_2(ot2), .control_mode, .ref_approach_mode, .fault_active,
    .enable_present, .main_power_ok, .drive_control_word, .motor_speed, .torque_actual,
    .torque_pos_limit, .torque_neg_limit, .load_pct, .brake_engaged, .following_error,
    .homing_done, .safety_enable, .alarm_clear_pulse, .reference_set_pulse,
    .reference_cam_pulse, .quick_stop_ramp, .quick_stop_request, .torque_limit_select,
    .speed_limit_select);

  function automatic logic [31:0] nxt(logic [31:0] x);
    return (x >> 1) ^ (x[0] ? 32'h8020_0003 : 32'h0);
  endfunction

  // expected status of each output function code
  function automatic logic st(int c);
    int ta, fe;
    ta = torque_actual < 0 ? -torque_actual : torque_actual;
    fe = following_error < 0 ? -following_error : following_error;
    case (c)
      1: return !fault_active && enable_present;
      2: return fault_active;
      3: return fe <= 40;
      4: return zero_speed_status;
      5: return ta + 16 >= int'(torque_actual < 0 ? torque_neg_limit : torque_pos_limit);
      6: return brake_engaged;
      7: return !fault_active && main_power_ok && (&drive_control_word[2:1]);
      8: return homing_done;
      9: return load_pct >= 9'h12c;
      10: return !safety_enable;
      default: return 1'b0;
    endcase
  endfunction

  task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wrap_up();
    if (mismatches == 0 && checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic wr(logic [7:0] a, logic [31:0] d);
    @(posedge clock);
    addr <= a;
    wdata <= d;
    wr_en <= 1;
    @(posedge clock);
    wr_en <= 0;
  endtask

  task automatic rd(logic [7:0] a, output logic [31:0] d);
    @(posedge clock);
    addr <= a;
    rd_en <= 1;
    @(posedge clock);
    rd_en <= 0;
    #1;
    d = rdata;
  endtask

  // hits < 0: level function, else number of one-cycle pulses expected
  task automatic pin_ev(int t, logic l, int b, logic exp, int hits);
    int k, first;
    k = 0;
    first = 0;
    @(posedge clock);
    lv[t] <= l;
    for (int n = 1; n < 3 * T; n++) begin
      @(posedge clock);
      #1;
      if (cmd[b] === exp) begin
        k++;
        if (first == 0)
          first = n;
      end
    end
    if (hits >= 0)
      check("pulse count", k, hits);
    else
      check("level", cmd[b], exp);
    if (hits != 0)
      check("latency in range", first >= T && first <= 2 * T + 6, 1);
    // hand back on an edge so that callers drive inputs there
    @(posedge clock);
  endtask

  initial begin
    #(8 * 20000);
    mismatches++;
    wrap_up();
  end

  initial begin
    repeat (20) @(posedge clock);
    srst <= 0;
    for (int j = 0; j < 8; j++) begin
      if (j != 6) begin
        rd(8'(4 * j), v);
        check("reset value", v, rst_v[j]);
      end
    end
    @(posedge clock);
    ce <= 0;
    wr(OFS_OUT_INV, 32'h0000_0003);
    ce <= 1;
    wr(8'h1c, 32'hffff_ffff);
    rd(OFS_OUT_INV, v);
    check("frozen write", v, 32'h0);
    rd(8'h1c, v);
    check("unmapped", v, 32'h0);
    wr(OFS_OLL_THR, 32'h0000_0190);
    rd(OFS_OLL_THR, v);
    check("overload clamp", v, 32'h0000_012c);
    // pins start low: alarm reset and torque select on terminals 1 and 2
    pin_ev(0, 1, 6, 1, 1);
    pin_ev(0, 1, 6, 1, 0);
    pin_ev(0, 0, 6, 1, 0);
    pin_ev(1, 1, 1, 1, -1);
    pin_ev(1, 0, 1, 0, -1);
    wr(OFS_IN_SEL, 32'h0000_5c0d);
    repeat (3 * T) @(posedge clock);
    pin_ev(2, 1, 0, 1, -1);
    pin_ev(2, 0, 0, 0, -1);
    pin_ev(3, 1, 2, 0, -1);
    pin_ev(3, 0, 2, 1, -1);
    pin_ev(0, 1, 5, 1, 1);
    pin_ev(0, 0, 5, 1, 0);
    ref_approach_mode <= 1;
    pin_ev(0, 1, 4, 1, 1);
    pin_ev(0, 0, 4, 1, 0);
    control_mode <= MODE_SPEED;
    pin_ev(0, 1, 4, 1, 0);
    // limits are held high before they are mapped
    lv[3:2] <= 2'h3;
    repeat (3 * T) @(posedge clock);
    wr(OFS_IN_SEL, 32'h0000_4300);
    repeat (3 * T) @(posedge clock);
    pin_ev(2, 0, 3, 1, 1);
    pin_ev(2, 1, 3, 1, 0);
    pin_ev(3, 0, 3, 1, 1);
    rd(OFS_STATUS, v);
    check("filtered pins", v[3:0], 4'h5);
    @(posedge clock);
    motor_speed <= 16'h0;
    for (int i = 0; i < 176; i++) begin
      @(posedge clock);
      lfsr = nxt(lfsr);
      r = lfsr;
      lfsr = nxt(lfsr);
      fault_active <= r[0];
      enable_present <= r[1];
      main_power_ok <= r[2];
      brake_engaged <= r[3];
      homing_done <= r[4];
      safety_enable <= r[5];
      drive_control_word <= {8'h00, r[15:8]};
      motor_speed <= i == 0 ? 16'h0 : {10'h000, r[21:16]};
      load_pct <= r[30:22];
      torque_actual <= $signed({8'h00, lfsr[7:0]}) - 16'sh0080;
      torque_pos_limit <= {9'h000, lfsr[14:8]};
      torque_neg_limit <= {9'h000, lfsr[21:15]};
      following_error <= $signed({8'h00, lfsr[29:22]}) - 16'sh0080;
      inv <= lfsr[31:30];
      wr(OFS_OUT_SEL, {24'h00_0000, 4'(i % 16), 4'(i % 16)});
      wr(OFS_OUT_INV, {30'h0, inv});
      repeat (3) @(posedge clock);
      #1;
      zero_speed_status = motor_speed <= 16'h0014 ? 1'b1 : (motor_speed > 16'h001e ? 1'b0 : zero_speed_status);
      check("out1", ot1, st(i % 16) ^ inv[0]);
      check("out2", ot2, st(i % 16) ^ inv[1]);
    end
    wrap_up();
  end
endmodule
